// [include/quad_enc_defines.svh]
// Constants for the two-drive quadrature encoder counter
`ifndef QUAD_ENC_DEFINES_SVH
`define QUAD_ENC_DEFINES_SVH
`define CNT_W 32
`define FB_CFG_ENC 8'h01
`define CLK_HZ 25000000
`define TRACK_MAX_HZ 100000
`define SAMPLE_HZ 4000
`define SAMPLE_CYC (`CLK_HZ / `SAMPLE_HZ)
`define EVAL_SINGLE 1'b0
`define EVAL_FOUR 1'b1
`endif

// [include/quad_enc_pkg.sv]
// Types for the two-drive quadrature encoder counter
package quad_enc_pkg;
  typedef enum logic [1:0] {
    DIR_NONE = 2'h0,
    DIR_RIGHT = 2'h1,
    DIR_LEFT = 2'h3
  } dir_t;
  typedef enum logic [1:0] {
    MEAS_IDLE = 2'h0,
    MEAS_RUN = 2'h1,
    MEAS_LATCH = 2'h3
  } meas_t;
endpackage

// [src/quad_track_decoder.sv]
// Synchroniser and edge decoder for one pair of encoder tracks
`timescale 1ns/10ps
`include "quad_enc_defines.svh"
module quad_track_decoder (
  input wire logic mclk, // Module clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic track_a, // Raw track A
  input wire logic track_b, // Raw track B
  input wire logic four_edge, // High selects four-edge evaluation
  output logic step_up, // One-cycle count pulse, right rotation
  output logic step_down // One-cycle count pulse, left rotation
);
  logic [1:0] meta; // First synchroniser stage
  logic [1:0] sync; // Second synchroniser stage
  logic [1:0] prev; // Previous synchronised state

  // Two flops per track before any edge logic
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meta <= 2'h0;
      sync <= 2'h0;
      prev <= 2'h0;
    end else begin
      meta <= {track_a, track_b}; // [RULE12]
      sync <= meta;
      prev <= sync;
    end
  end

  // Decode transitions; A leading B is right, A lagging B is left
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      step_up <= 1'b0;
      step_down <= 1'b0;
    end else if (four_edge == `EVAL_FOUR) begin
      // Every edge of either track counts; direction from phase [RULE4]
      step_up <= (prev[1] ^ sync[1]) & (sync[1] ^ sync[0]) |
                 (prev[0] ^ sync[0]) & ~(sync[1] ^ sync[0]); // [RULE1]
      step_down <= (prev[1] ^ sync[1]) & ~(sync[1] ^ sync[0]) |
                   (prev[0] ^ sync[0]) & (sync[1] ^ sync[0]); // [RULE2]
    end else begin
      // Only rising A counts; B level gives direction [RULE3]
      step_up <= ~prev[1] & sync[1] & ~sync[0]; // [RULE1]
      step_down <= ~prev[1] & sync[1] & sync[0]; // [RULE2]
    end
  end
endmodule

// [src/quadrature_encoder_counter.sv]
// Two-drive quadrature encoder counter with velocity and acceleration
// Notes on behaviour
// [RULE1] A leading B means right, positive
// [RULE2] A lagging B means left, negative
// [RULE3] Single-edge: count rising A only
// [RULE4] Four-edge: count every edge of both
// [RULE5] Speed and direction from counter differences
// [RULE6] Config value one routes port_one, port_three
// [RULE7] Count readable as encoder actual value
// [RULE8] Drive 2 uses port_two and port_four
// [RULE9] Count correctly up to 100 kHz tracks
// [RULE10] Unused ports stay free for digital use
// [RULE11] Position, velocity, acceleration computed internally
// [RULE12] Synchronise, up right, down left, wrap
`timescale 1ns/10ps
`include "quad_enc_defines.svh"
module quadrature_encoder_counter (
  input wire logic mclk, // Module clock, 25 MHz
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [3:0] port_in, // Ports one..four input levels
  input wire logic [7:0] fb_cfg_1, // Drive 1 feedback configuration
  input wire logic [7:0] fb_cfg_2, // Drive 2 feedback configuration
  input wire logic eval_mode_1, // Drive 1 evaluation, high four-edge
  input wire logic eval_mode_2, // Drive 2 evaluation, high four-edge
  output logic [31:0] enc_actual_1, // Drive 1 encoder actual value
  output logic [31:0] enc_actual_2, // Drive 2 encoder actual value
  output logic [31:0] velocity_1, // Drive 1 counts per sample
  output logic [31:0] velocity_2, // Drive 2 counts per sample
  output logic [31:0] accel_1, // Drive 1 velocity change per sample
  output logic [31:0] accel_2, // Drive 2 velocity change per sample
  output quad_enc_pkg::dir_t dir_1, // Drive 1 movement direction
  output quad_enc_pkg::dir_t dir_2, // Drive 2 movement direction
  output logic closed_loop_1, // Drive 1 loops closed on encoder
  output logic closed_loop_2, // Drive 2 loops closed on encoder
  output logic [3:0] dio_free, // Ports left for digital use
  output logic sample_tick // One-cycle pulse, one cycle before the velocity outputs update
);
  // Sample period in cycles, derived from clock and sample rate
  localparam int SAMPLE_CYC = `SAMPLE_CYC;

  logic [1:0] enc_en; // Per-drive encoder enable
  logic [1:0] mode; // Per-drive evaluation mode
  logic [1:0] up; // Per-drive up pulses
  logic [1:0] down; // Per-drive down pulses
  logic [31:0] count [2]; // Running counters
  logic [31:0] last [2]; // Count at previous sample
  logic [31:0] vel [2]; // Last velocity
  logic [31:0] acc [2]; // Last acceleration
  logic [15:0] tick_cnt; // Sample timer
  quad_enc_pkg::meas_t meas; // Measurement sequencer
  quad_enc_pkg::dir_t dir_v [2]; // Direction from differences

  // Decode the feedback entry once, used for both drives
  function automatic logic cfg_is_enc(input logic [7:0] cfg);
    cfg_is_enc = (cfg == `FB_CFG_ENC);
  endfunction

  assign mode = {eval_mode_2, eval_mode_1};

  // Enable latch; decoded config drives the routing below
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      enc_en <= 2'h0;
    end else begin
      enc_en[0] <= cfg_is_enc(fb_cfg_1); // [RULE6]
      enc_en[1] <= cfg_is_enc(fb_cfg_2); // [RULE8]
    end
  end

  // One decoder per drive; drive d uses ports d and d+2
  genvar d;
  generate
    for (d = 0; d < 2; d++) begin : g_drv
      logic [31:0] diff; // Counts moved this sample
      quad_track_decoder u_dec (
        .mclk(mclk),
        .rst_n(rst_n),
        .track_a(port_in[d] & enc_en[d]), // [RULE6] [RULE8]
        .track_b(port_in[d+2] & enc_en[d]),
        .four_edge(mode[d]),
        .step_up(up[d]),
        .step_down(down[d])
      );

      // Counter: one pulse per cycle at most, which at 25 MHz easily
      // covers four edges per 100 kHz period; wraps naturally
      always_ff @(posedge mclk) begin
        if (!rst_n || !enc_en[d]) begin
          count[d] <= 32'h0;
        end else if (up[d]) begin
          count[d] <= count[d] + 32'h1; // [RULE12] [RULE9]
        end else if (down[d]) begin
          count[d] <= count[d] - 32'h1; // [RULE12]
        end
      end

      assign diff = count[d] - last[d];

      // Velocity and direction from successive readings
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          last[d] <= 32'h0;
          vel[d] <= 32'h0;
          acc[d] <= 32'h0;
          dir_v[d] <= quad_enc_pkg::DIR_NONE;
        end else if (meas == quad_enc_pkg::MEAS_LATCH) begin
          last[d] <= count[d];
          vel[d] <= diff; // [RULE5] [RULE11]
          acc[d] <= diff - vel[d]; // [RULE11]
          if (diff == 32'h0) begin
            dir_v[d] <= quad_enc_pkg::DIR_NONE; // Standing still
          end else if (diff[31]) begin
            dir_v[d] <= quad_enc_pkg::DIR_LEFT; // [RULE5]
          end else begin
            dir_v[d] <= quad_enc_pkg::DIR_RIGHT; // [RULE5]
          end
        end
      end
    end
  endgenerate

  // Sample sequencer: waits a period, then latches one cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      meas <= quad_enc_pkg::MEAS_IDLE;
      tick_cnt <= 16'h0;
    end else begin
      case (meas)
        quad_enc_pkg::MEAS_IDLE: begin
          meas <= quad_enc_pkg::MEAS_RUN;
          tick_cnt <= 16'h0;
        end
        quad_enc_pkg::MEAS_RUN: begin
          if (tick_cnt == 16'(SAMPLE_CYC - 2)) begin
            meas <= quad_enc_pkg::MEAS_LATCH;
          end else begin
            tick_cnt <= tick_cnt + 16'h1;
          end
        end
        quad_enc_pkg::MEAS_LATCH: begin
          meas <= quad_enc_pkg::MEAS_IDLE;
        end
        default: begin
          meas <= quad_enc_pkg::MEAS_IDLE;
        end
      endcase
    end
  end

  // Registered outputs; free ports follow the enables
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      enc_actual_1 <= 32'h0;
      enc_actual_2 <= 32'h0;
      velocity_1 <= 32'h0;
      velocity_2 <= 32'h0;
      accel_1 <= 32'h0;
      accel_2 <= 32'h0;
      dir_1 <= quad_enc_pkg::DIR_NONE;
      dir_2 <= quad_enc_pkg::DIR_NONE;
      closed_loop_1 <= 1'b0;
      closed_loop_2 <= 1'b0;
      dio_free <= 4'hF;
      sample_tick <= 1'b0;
    end else begin
      enc_actual_1 <= count[0]; // [RULE7]
      enc_actual_2 <= count[1]; // [RULE7]
      velocity_1 <= vel[0];
      velocity_2 <= vel[1];
      accel_1 <= acc[0];
      accel_2 <= acc[1];
      dir_1 <= dir_v[0];
      dir_2 <= dir_v[1];
      closed_loop_1 <= enc_en[0]; // [RULE11]
      closed_loop_2 <= enc_en[1]; // [RULE11]
      // Bit order is port_four, port_three, port_two, port_one
      dio_free <= {~enc_en[1], ~enc_en[0],
                   ~enc_en[1], ~enc_en[0]}; // [RULE10]
      sample_tick <= (meas == quad_enc_pkg::MEAS_LATCH);
    end
  end
endmodule

// [bench/quad_enc_asserts.sv]
// Checker for the quadrature encoder counter
`timescale 1ns/10ps
module quad_enc_asserts (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [7:0] fb_cfg_1, // Config 1
  input wire logic [7:0] fb_cfg_2, // Config 2
  input wire logic [31:0] enc_actual_1, // Count 1
  input wire logic [31:0] velocity_1, // Speed 1
  input wire logic [31:0] accel_1, // Accel 1
  input wire quad_enc_pkg::dir_t dir_1, // Direction 1
  input wire logic closed_loop_1, // Loop 1
  input wire logic closed_loop_2, // Loop 2
  input wire logic [3:0] dio_free, // Free ports
  input wire logic sample_tick // Tick
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Config is latched, then registered out: two cycles to the flag
  property p_en1; 1 |-> closed_loop_1 == ($past(fb_cfg_1, 2) == 8'h01);
  endproperty
  a_en1: assert property (p_en1)
    else $error("drive 1 enable wrong");
  property p_en2; fb_cfg_2 == 8'h01 |-> ##2 closed_loop_2; endproperty
  a_en2: assert property (p_en2)
    else $error("drive 2 enable wrong");
  property p_free; dio_free == {~closed_loop_2, ~closed_loop_1,
    ~closed_loop_2, ~closed_loop_1}; endproperty
  a_free: assert property (p_free)
    else $error("free ports wrong");
  // Steps are spaced, so a live counter moves by one at a time
  property p_step; closed_loop_1 && $past(closed_loop_1) &&
    $changed(enc_actual_1) |->
    enc_actual_1 - $past(enc_actual_1) inside {32'h1, 32'hFFFFFFFF};
  endproperty
  a_step: assert property (p_step)
    else $error("count jumped");
  // The tick leaves one cycle ahead of the registered speed
  property p_vel; $changed(velocity_1) |-> $past(sample_tick); endproperty
  a_vel: assert property (p_vel)
    else $error("speed moved off sample");
  property p_acc; $changed(accel_1) |-> $past(sample_tick); endproperty
  a_acc: assert property (p_acc)
    else $error("accel moved off sample");
  property p_right; dir_1 == quad_enc_pkg::DIR_RIGHT |->
    !velocity_1[31] && velocity_1 != 32'h0; endproperty
  a_right: assert property (p_right)
    else $error("right without rising count");
  property p_left; dir_1 == quad_enc_pkg::DIR_LEFT |-> velocity_1[31];
  endproperty
  a_left: assert property (p_left)
    else $error("left without falling count");
endmodule
bind quadrature_encoder_counter quad_enc_asserts i_quad_enc_asserts (
  .mclk, .rst_n, .fb_cfg_1, .fb_cfg_2, .enc_actual_1, .velocity_1,
  .accel_1, .dir_1, .closed_loop_1, .closed_loop_2, .dio_free,
  .sample_tick);

// [bench/quad_enc_model.sv]
// Behavioural two-track encoder for one port pair
`timescale 1ns/10ps
module quad_enc_model (
  input wire logic mclk, // Clock
  input wire logic step, // Move a quarter period
  input wire logic right, // High moves right
  output logic track_a, // Track A level
  output logic track_b // Track B level
);
  logic [1:0] phase = 2'h0; // Position in the cycle
  // Right walks forward so A leads B, left walks back
  always_ff @(posedge mclk) begin
    if (step) begin
      phase <= right ? phase + 2'h1 : phase - 2'h1;
    end
  end
  // Rate is held under the limit by the bench step spacing
  assign track_a = phase[0] ^ phase[1];
  assign track_b = phase[1];
endmodule

// [bench/test_quadrature_encoder_counter.sv]
// Self-checking bench for the quadrature encoder counter
`timescale 1ns/10ps
module test_quadrature_encoder_counter;
  logic mclk = 1'b0; // Clock
  logic rst_n = 1'b0; // Reset
  wire [3:0] port_in; // Tracks of both encoders
  logic [7:0] fb_cfg_1 = 8'h00; // Drive 1 config
  logic [7:0] fb_cfg_2 = 8'h00; // Drive 2 config
  logic eval_mode_1 = 1'b1; // Drive 1 mode
  logic eval_mode_2 = 1'b1; // Drive 2 mode
  logic [31:0] enc_actual_1, enc_actual_2, velocity_1, velocity_2;
  logic [31:0] accel_1, accel_2;
  quad_enc_pkg::dir_t dir_1, dir_2;
  logic closed_loop_1, closed_loop_2, sample_tick;
  logic [3:0] dio_free;
  logic [1:0] step = 2'h0; // Model requests
  logic [1:0] right = 2'h0; // Model directions
  logic [1:0] ph [2] = '{2'h0, 2'h0}; // Expected phases
  logic [31:0] exp [2] = '{32'h0, 32'h0}; // Expected counts
  int error_cnt = 0;
  int total_checks = 0;
  always #20 mclk = ~mclk;
  quad_enc_model i_quad_enc_model (.mclk, .step(step[0]),
    .right(right[0]), .track_a(port_in[0]), .track_b(port_in[2]));
  quad_enc_model i_quad_enc_model_b (.mclk, .step(step[1]),
    .right(right[1]), .track_a(port_in[1]), .track_b(port_in[3]));
  quadrature_encoder_counter i_quadrature_encoder_counter (.mclk, .rst_n,
    .port_in, .fb_cfg_1, .fb_cfg_2, .eval_mode_1, .eval_mode_2,
    .enc_actual_1, .enc_actual_2, .velocity_1, .velocity_2, .accel_1,
    .accel_2, .dir_1, .dir_2, .closed_loop_1, .closed_loop_2,
    .dio_free, .sample_tick);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("wrong value at %0t: %h vs %h", $time, seen, want);
    end
  endtask
  // Count change for one quarter step; single mode sees rising A only
  function automatic logic [31:0] delta(input logic [1:0] p,
      input logic r, input logic four);
    if (four || (r ? p == 2'h0 : p == 2'h3)) return r ? 32'h1 : '1;
    return 32'h0;
  endfunction
  // Spacing of 70 cycles keeps four-edge under the top track rate
  task automatic move(input int d, input int n, input logic r);
    for (int i = 0; i < n; i++) begin
      if ((d ? fb_cfg_2 : fb_cfg_1) == 8'h01)
        exp[d] += delta(ph[d], r, d ? eval_mode_2 : eval_mode_1);
      ph[d] = r ? ph[d] + 2'h1 : ph[d] - 2'h1;
      step[d] <= 1'b1;
      right[d] <= r;
      @(posedge mclk);
      step[d] <= 1'b0;
      repeat (69) @(posedge mclk);
    end
  endtask
  task automatic verify();
    repeat (8) @(posedge mclk);
    check(enc_actual_1, exp[0]);
    check(enc_actual_2, exp[1]);
    $display("test done at %0t", $time);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog well beyond the planned run
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt++;
    conclude();
  end
  initial begin
    void'($urandom(32'hafc5));
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check(dio_free, 4'hF);
    move(0, 8, 1'b1);
    verify();
    fb_cfg_1 <= 8'h01;
    // Latch plus output register; read after both have settled
    repeat (3) @(posedge mclk);
    check(dio_free, 4'hA);
    move(0, 200, 1'b1);
    check(dir_1, quad_enc_pkg::DIR_RIGHT);
    verify();
    move(0, $urandom_range(50, 10), 1'b0);
    verify();
    eval_mode_1 <= 1'b0;
    // Let the new mode land before move reads it for the expectation
    @(posedge mclk);
    for (int k = 0; k < 6; k++)
      move(0, $urandom_range(9, 1), $urandom_range(1, 0));
    verify();
    fb_cfg_2 <= 8'h01;
    repeat (2) @(posedge mclk);
    move(1, 1, 1'b0);
    verify();
    fb_cfg_1 <= 8'h00;
    exp[0] = 32'h0;
    verify();
    conclude();
  end
endmodule
